// [pkg/cstd_pkg.sv]
// constants, field layouts and carrier types of the card command block
// assumes one 125 MHz clock domain and a 32-bit avalon-mm register slave
package cstd_pkg;

  localparam logic [7:0] CMD_STBY_IMM_A = 8'h94;
  localparam logic [7:0] CMD_STBY_IMM_B = 8'hE0;
  localparam logic [7:0] CMD_TRANSLATE  = 8'h87;
  localparam logic [7:0] CMD_WEAR_LEVEL = 8'hF5;
  localparam logic [7:0] CMD_WRITE_BUF  = 8'hE8;
  localparam logic [7:0] CMD_WRITE_DMA  = 8'hCA;

  localparam logic [5:0] REG_DATA     = 6'h00;
  localparam logic [5:0] REG_FEAT_ERR = 6'h04;
  localparam logic [5:0] REG_SECCNT   = 6'h08;
  localparam logic [5:0] REG_SECNUM   = 6'h0C;
  localparam logic [5:0] REG_CYL_LO   = 6'h10;
  localparam logic [5:0] REG_CYL_HI   = 6'h14;
  localparam logic [5:0] REG_DRVHEAD  = 6'h18;
  localparam logic [5:0] REG_CMD_STAT = 6'h1C;
  localparam logic [5:0] REG_CFG      = 6'h20;

  localparam int CFG_SECURITY_BIT = 0;
  localparam int CFG_EIGHT_BIT    = 1;
  localparam int DH_LBA_BIT       = 6;
  localparam int DH_DRIVE_BIT     = 4;
  localparam int STAT_BUSY_BIT    = 7;
  localparam int STAT_READY_BIT   = 6;
  localparam int STAT_DRQ_BIT     = 3;
  localparam int STAT_ERR_BIT     = 0;
  localparam int ERR_ABRT_BIT     = 2;

  localparam logic [7:0] WORD_LAST     = 8'hFF;
  localparam logic [8:0] SECTORS_MAX   = 9'h100;
  localparam logic [7:0] WEAR_NOT_NEED = 8'h00;

  localparam logic [8:0] RPT_CYL_MSB   = 9'h000;
  localparam logic [8:0] RPT_CYL_LSB   = 9'h001;
  localparam logic [8:0] RPT_HEAD      = 9'h002;
  localparam logic [8:0] RPT_SECTOR    = 9'h003;
  localparam logic [8:0] RPT_LBA_MSB   = 9'h004;
  localparam logic [8:0] RPT_LBA_MID   = 9'h005;
  localparam logic [8:0] RPT_LBA_LSB   = 9'h006;
  localparam logic [8:0] RPT_ERASED    = 9'h013;
  localparam logic [8:0] RPT_HOT_MSB   = 9'h018;
  localparam logic [8:0] RPT_HOT_MID   = 9'h019;
  localparam logic [8:0] RPT_HOT_LSB   = 9'h01A;
  localparam logic [7:0] RPT_ERASED_Y  = 8'hFF;
  localparam logic [7:0] RPT_ERASED_N  = 8'h00;

  localparam int DEF_HEADS        = 16;
  localparam int DEF_SECT_PER_TRK = 63;

  typedef struct packed {
    logic        lba_mode;
    logic [3:0]  head;
    logic [15:0] cyl;
    logic [7:0]  sec;
  } cstd_chs_t;

endpackage : cstd_pkg

// [src/cstd_sector_buf.sv]
// one-sector buffer of 16-bit words held in flip-flops
// assumes writes and reads are indexed by word; read data is registered
`timescale 1ns/1ps
module cstd_sector_buf
  import cstd_pkg::*;
#(
  parameter int WORDS = 256
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     we,
  input  wire logic [$clog2(WORDS)-1:0] widx,
  input  wire logic [15:0]              wdata,
  input  wire logic [$clog2(WORDS)-1:0] ridx,
  output logic      [15:0]              rdata
);

  typedef struct packed {
    logic [WORDS-1:0][15:0] mem;
    logic [15:0]            rd;
  } cstd_buf_state_t;

  cstd_buf_state_t s;
  cstd_buf_state_t next_s;

  always_comb begin
    next_s = s;
    if (we) begin
      next_s.mem[widx] = wdata;
    end
    next_s.rd = s.mem[ridx];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rd;

endmodule : cstd_sector_buf

// [src/cstd_report_gen.sv]
// builds one 16-bit word of the 512-byte sector translation report
// assumes low byte of a word is the even report byte; purely combinational
`timescale 1ns/1ps
module cstd_report_gen
  import cstd_pkg::*;
#(
  parameter int HEADS        = DEF_HEADS,
  parameter int SECT_PER_TRK = DEF_SECT_PER_TRK,
  parameter bit HOT_COUNT    = 1'b1
) (
  input  wire cstd_chs_t   addr,
  input  wire logic        erased,
  input  wire logic [23:0] erase_count,
  input  wire logic [7:0]  word_idx,
  output logic      [15:0] word
);

  logic [31:0] lba_full;
  logic [23:0] lba;
  logic [23:0] hot;

  always_comb begin
    if (addr.lba_mode) begin
      lba_full = {8'h00, addr.cyl, addr.sec};
    end else begin
      lba_full = ({16'h0000, addr.cyl} * 32'(HEADS) + {28'h0000000, addr.head}) * 32'(SECT_PER_TRK)
                 + {24'h000000, addr.sec} - 32'h00000001;
    end
    lba = lba_full[23:0];
    hot = HOT_COUNT ? erase_count : 24'h000000;
  end

  function automatic logic [7:0] rpt_byte(input logic [8:0] b);
    logic [7:0] v;
    v = 8'h00;
    unique case (b)
      RPT_CYL_MSB: v = addr.cyl[15:8];
      RPT_CYL_LSB: v = addr.cyl[7:0];
      RPT_HEAD:    v = {4'h0, addr.head};
      RPT_SECTOR:  v = addr.sec;
      RPT_LBA_MSB: v = lba[23:16];
      RPT_LBA_MID: v = lba[15:8];
      RPT_LBA_LSB: v = lba[7:0];
      RPT_ERASED:  v = erased ? RPT_ERASED_Y : RPT_ERASED_N;
      RPT_HOT_MSB: v = hot[23:16];
      RPT_HOT_MID: v = hot[15:8];
      RPT_HOT_LSB: v = hot[7:0];
      default:     v = 8'h00;
    endcase
    return v;
  endfunction : rpt_byte

  assign word = {rpt_byte({word_idx, 1'b1}), rpt_byte({word_idx, 1'b0})};

endmodule : cstd_report_gen

// [src/cstd_core.sv]
// task-file command interpreter for standby, translate, wear level,
// write buffer and dma write, with an avalon-mm register slave
// assumes host dma pins are synchronous to clk; the flash backend answers
// each sector commit with one flash_done pulse
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module cstd_core
  import cstd_pkg::*;
#(
  parameter int HEADS        = DEF_HEADS,
  parameter int SECT_PER_TRK = DEF_SECT_PER_TRK,
  parameter bit HOT_COUNT    = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             dma_request_line,
  input  wire logic        dma_acknowledge_n,
  input  wire logic        io_write_strobe_n,
  input  wire logic [15:0] dma_data,
  output logic             intrq,
  output logic             sleep_mode,
  output logic             security_frozen,
  output logic             sector_commit,
  output cstd_chs_t        sector_addr,
  input  wire logic [7:0]  buf_rd_idx,
  output logic      [15:0] buf_rd_data,
  input  wire logic        flash_done,
  input  wire logic        flash_error,
  input  wire logic        sector_erased,
  input  wire logic [23:0] erase_count
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_STBY,
    S_PIO_WR,
    S_PIO_RD,
    S_DMA_PREP,
    S_DMA,
    S_COMMIT
  } cstd_state_e_t;

  typedef struct packed {
    cstd_state_e_t st;
    cstd_chs_t     addr;
    logic          drive;
    logic [7:0]    feature;
    logic [7:0]    seccnt;
    logic [1:0]    cfg;
    logic          busy;
    logic          data_request_flag;
    logic          err;
    logic          abrt;
    logic          intrq;
    logic          sleep;
    logic          frozen;
    logic          ack_q;
    logic [31:0]   rdata;
    logic [7:0]    widx;
    logic [8:0]    remaining;
    logic          io_prev;
    logic          commit;
  } cstd_core_state_t;

  cstd_core_state_t s;
  cstd_core_state_t next_s;

  logic        buf_we;
  logic [7:0]  buf_widx;
  logic [15:0] buf_wdata;
  logic [15:0] rpt_word;
  logic        accept;
  logic        dma_word;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////

  cstd_sector_buf #(
    .WORDS (256)
  ) u_buf (
    .clk   (clk),
    .rst   (rst),
    .we    (buf_we),
    .widx  (buf_widx),
    .wdata (buf_wdata),
    .ridx  (buf_rd_idx),
    .rdata (buf_rd_data)
  );

  cstd_report_gen #(
    .HEADS        (HEADS),
    .SECT_PER_TRK (SECT_PER_TRK),
    .HOT_COUNT    (HOT_COUNT)
  ) u_rpt (
    .addr        (s.addr),
    .erased      (sector_erased),
    .erase_count (erase_count),
    .word_idx    (s.widx),
    .word        (rpt_word)
  );

  ////////////////////////////////////////////////////////////////////////////

  // next sector in lba or chs order
  function automatic cstd_chs_t next_addr(input cstd_chs_t a);
    cstd_chs_t r;
    logic [27:0] l;
    r = a;
    if (a.lba_mode) begin
      l = {a.head, a.cyl, a.sec} + 28'h0000001;
      r.head = l[27:24];
      r.cyl  = l[23:8];
      r.sec  = l[7:0];
    end else if (a.sec < 8'(SECT_PER_TRK)) begin
      r.sec = a.sec + 8'h01;
    end else begin
      r.sec = 8'h01;
      if (a.head < 4'(HEADS - 1)) begin
        r.head = a.head + 4'h1;
      end else begin
        r.head = 4'h0;
        r.cyl  = a.cyl + 16'h0001;
      end
    end
    return r;
  endfunction : next_addr

  function automatic logic [7:0] status_byte(input cstd_core_state_t x);
    logic [7:0] v;
    v = 8'h00;
    v[STAT_BUSY_BIT]  = x.busy;
    v[STAT_READY_BIT] = ~x.busy;
    v[STAT_DRQ_BIT]   = x.data_request_flag;
    v[STAT_ERR_BIT]   = x.err;
    return v;
  endfunction : status_byte

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (avs_address)
      REG_DATA:     rd_mux = (s.st == S_PIO_RD) ? {16'h0000, rpt_word} : 32'h00000000;
      REG_FEAT_ERR: rd_mux = {29'h00000000, s.abrt, 2'b00};
      REG_SECCNT:   rd_mux = {24'h000000, s.seccnt};
      REG_SECNUM:   rd_mux = {24'h000000, s.addr.sec};
      REG_CYL_LO:   rd_mux = {24'h000000, s.addr.cyl[7:0]};
      REG_CYL_HI:   rd_mux = {24'h000000, s.addr.cyl[15:8]};
      REG_DRVHEAD:  rd_mux = {24'h000000, 1'b1, s.addr.lba_mode, 1'b1, s.drive, s.addr.head};
      REG_CMD_STAT: rd_mux = {24'h000000, status_byte(s)};
      REG_CFG:      rd_mux = {30'h00000000, s.cfg};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    next_s         = s;
    next_s.commit  = 1'b0;
    next_s.io_prev = io_write_strobe_n;
    buf_we         = 1'b0;
    buf_widx       = s.widx;
    buf_wdata      = dma_data;
    accept         = (avs_read | avs_write) & s.ack_q;
    next_s.ack_q   = (avs_read | avs_write) & ~s.ack_q;
    dma_word       = (s.st == S_DMA) & s.io_prev & ~io_write_strobe_n & ~dma_acknowledge_n;
    if (avs_read & ~s.ack_q) begin
      next_s.rdata = rd_mux;
    end

    // register reads with side effects
    if (accept & avs_read) begin
      if (avs_address == REG_CMD_STAT) begin
        next_s.intrq = 1'b0;
      end
      if (avs_address == REG_DATA && s.st == S_PIO_RD) begin
        next_s.widx = s.widx + 8'h01;
        if (s.widx == WORD_LAST) begin
          next_s.st  = S_IDLE;
          next_s.data_request_flag = 1'b0;
        end
      end
    end

    // register writes; fields a command does not use are simply never read
    if (accept & avs_write) begin
      unique case (avs_address)
        REG_DATA: begin
          if (s.st == S_PIO_WR) begin
            buf_we      = 1'b1;
            buf_wdata   = avs_writedata[15:0];
            next_s.widx = s.widx + 8'h01;
            if (s.widx == WORD_LAST) begin
              next_s.st    = S_IDLE;
              next_s.data_request_flag   = 1'b0;
              next_s.intrq = 1'b1;
            end
          end
        end
        REG_FEAT_ERR: next_s.feature = avs_writedata[7:0];
        REG_SECCNT:   next_s.seccnt = avs_writedata[7:0];
        REG_SECNUM:   next_s.addr.sec = avs_writedata[7:0];
        REG_CYL_LO:   next_s.addr.cyl[7:0] = avs_writedata[7:0];
        REG_CYL_HI:   next_s.addr.cyl[15:8] = avs_writedata[7:0];
        REG_DRVHEAD: begin
          next_s.addr.lba_mode = avs_writedata[DH_LBA_BIT];
          next_s.drive         = avs_writedata[DH_DRIVE_BIT];
          next_s.addr.head     = avs_writedata[3:0];
        end
        REG_CFG:      next_s.cfg = avs_writedata[1:0];
        REG_CMD_STAT: begin
          next_s.sleep = 1'b0;
          next_s.err   = 1'b0;
          next_s.abrt  = 1'b0;
          next_s.intrq = 1'b0;
          next_s.widx  = 8'h00;
          unique case (avs_writedata[7:0])
            CMD_STBY_IMM_A, CMD_STBY_IMM_B: begin
              next_s.busy = 1'b1;
              next_s.st   = S_STBY;
            end
            CMD_TRANSLATE: begin
              next_s.data_request_flag = 1'b1;
              next_s.st  = S_PIO_RD;
            end
            CMD_WEAR_LEVEL: begin
              if (s.cfg[CFG_SECURITY_BIT]) begin
                next_s.frozen = 1'b1;
              end else begin
                next_s.seccnt = WEAR_NOT_NEED;
              end
              next_s.intrq = 1'b1;
            end
            CMD_WRITE_BUF: begin
              next_s.data_request_flag = 1'b1;
              next_s.st  = S_PIO_WR;
            end
            CMD_WRITE_DMA: begin
              if (s.cfg[CFG_EIGHT_BIT]) begin
                next_s.err   = 1'b1;
                next_s.abrt  = 1'b1;
                next_s.intrq = 1'b1;
              end else begin
                next_s.busy      = 1'b1;
                next_s.remaining = (s.seccnt == 8'h00) ? SECTORS_MAX : {1'b0, s.seccnt};
                next_s.st        = S_DMA_PREP;
              end
            end
            default: begin
              next_s.err   = 1'b1;
              next_s.abrt  = 1'b1;
              next_s.intrq = 1'b1;
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    unique case (s.st)
      S_STBY: begin
        next_s.sleep = 1'b1;
        next_s.busy  = 1'b0;
        next_s.intrq = 1'b1;
        next_s.st    = S_IDLE;
      end
      S_DMA_PREP: begin
        next_s.busy = 1'b0;
        next_s.data_request_flag  = 1'b1;
        next_s.st   = S_DMA;
      end
      S_DMA: begin
        if (dma_word) begin
          buf_we      = 1'b1;
          buf_wdata   = dma_data;
          next_s.widx = s.widx + 8'h01;
          if (s.widx == WORD_LAST) begin
            next_s.st     = S_COMMIT;
            next_s.busy   = 1'b1;
            next_s.data_request_flag    = 1'b0;
            next_s.commit = 1'b1;
          end
        end
      end
      S_COMMIT: begin
        if (flash_done) begin
          if (flash_error) begin
            next_s.err   = 1'b1;
            next_s.busy  = 1'b0;
            next_s.intrq = 1'b1;
            next_s.st    = S_IDLE;
          end else if (s.remaining == 9'h001) begin
            next_s.busy  = 1'b0;
            next_s.intrq = 1'b1;
            next_s.st    = S_IDLE;
          end else begin
            next_s.addr      = next_addr(s.addr);
            next_s.remaining = s.remaining - 9'h001;
            next_s.busy      = 1'b0;
            next_s.data_request_flag       = 1'b1;
            next_s.st        = S_DMA;
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s         <= '0;
      s.st      <= S_IDLE;
      s.io_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign avs_waitrequest  = (avs_read | avs_write) & ~s.ack_q;
  assign avs_readdata     = s.rdata;
  assign dma_request_line = (s.st == S_DMA);
  assign intrq            = s.intrq;
  assign sleep_mode       = s.sleep;
  assign security_frozen  = s.frozen;
  assign sector_commit    = s.commit;
  assign sector_addr      = s.addr;

endmodule : cstd_core

// [test/cstd_core_sva.sv]
// checker for the card command block, watching cstd_core ports only
// assumes the task-file offsets and config bits of cstd_pkg
`timescale 1ns/1ps
module cstd_core_sva
  import cstd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        dma_request_line,
  input wire logic        dma_acknowledge_n,
  input wire logic        io_write_strobe_n,
  input wire logic        intrq,
  input wire logic        sleep_mode,
  input wire logic        sector_commit,
  input wire cstd_chs_t   sector_addr,
  input wire logic        flash_done,
  input wire logic        flash_error
);
  logic       cmd_tk;
  logic       stby_tk;
  logic       ca_tk;
  logic       eight;
  logic       stb_q;
  logic [7:0] wcnt;
  assign cmd_tk  = avs_write && !avs_waitrequest && avs_address == REG_CMD_STAT;
  assign stby_tk = cmd_tk && (avs_writedata[7:0] == CMD_STBY_IMM_A || avs_writedata[7:0] == CMD_STBY_IMM_B);
  assign ca_tk   = cmd_tk && avs_writedata[7:0] == CMD_WRITE_DMA;
  // mirrors the eight-bit mode bit and counts dma words taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eight <= 1'b0;
      stb_q <= 1'b1;
      wcnt  <= 8'h00;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == REG_CFG)
        eight <= avs_writedata[CFG_EIGHT_BIT];
      stb_q <= io_write_strobe_n;
      if (stb_q && !io_write_strobe_n && !dma_acknowledge_n && dma_request_line)
        wcnt <= wcnt + 8'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_stby_sleep_intr: assert property (stby_tk |-> ##2 (sleep_mode && intrq))
    else $error("standby did not sleep with interrupt");
  a_wake_on_cmd: assert property (sleep_mode && cmd_tk |=> !sleep_mode)
    else $error("new command did not wake the card");
  a_dma_start_seq: assert property (ca_tk && !eight |=> !dma_request_line ##1 dma_request_line)
    else $error("dma write did not start after one busy cycle");
  a_eight_bit_abort: assert property (ca_tk && eight |-> ##[1:2] (intrq && !dma_request_line))
    else $error("dma write not aborted in eight-bit mode");
  a_req_until_full: assert property ($fell(dma_request_line) |-> wcnt == 8'h00)
    else $error("dma request dropped before a full sector");
  a_no_sector_intr: assert property (sector_commit |-> !intrq)
    else $error("interrupt raised in mid transfer");
  a_err_stop_intr: assert property (flash_done && flash_error |-> ##[1:2] (intrq && !dma_request_line))
    else $error("error did not end the dma write");
  a_err_addr_kept: assert property (flash_done && flash_error |=> $stable(sector_addr))
    else $error("failing sector address not kept");
  a_addr_in_sector: assert property (dma_request_line && $past(dma_request_line) |-> $stable(sector_addr))
    else $error("sector address moved during a sector");
  c_standby: cover property (stby_tk);
  c_sector_done: cover property ($fell(dma_request_line));
  c_flash_err: cover property (flash_done && flash_error);
endmodule : cstd_core_sva

bind cstd_core cstd_core_sva chk_i (.clk, .rst, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest,
  .dma_request_line, .dma_acknowledge_n, .io_write_strobe_n, .intrq, .sleep_mode, .sector_commit,
  .sector_addr, .flash_done, .flash_error);

// [test/cstd_host_model.sv]
// host dma side: acknowledges and strobes one word per low pulse
// assumes the card request is synchronous to clk; slow paces every 4 cycles
`timescale 1ns/1ps
module cstd_host_model
  import cstd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        dma_request_line,
  output logic             dma_acknowledge_n,
  output logic             io_write_strobe_n,
  output logic      [15:0] dma_data
);
  logic [15:0] idx;
  logic [1:0]  pace;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_acknowledge_n <= 1'b1;
      io_write_strobe_n <= 1'b1;
      dma_data          <= 16'h0000;
      idx               <= 16'h0000;
      pace              <= 2'h0;
    end else if (dma_request_line) begin
      pace              <= pace + 2'h1;
      dma_acknowledge_n <= 1'b0;
      if (!dma_acknowledge_n && (!slow || pace == 2'h0)) begin
        io_write_strobe_n <= !io_write_strobe_n;
        if (io_write_strobe_n) begin
          dma_data <= idx;
          idx      <= idx + 16'h0001;
        end
      end
    end else begin
      dma_acknowledge_n <= 1'b1;
      io_write_strobe_n <= 1'b1;
      dma_data          <= ~dma_data; // released bus alternates the last word with its inverse
    end
  end
endmodule : cstd_host_model

// [test/test_cstd_core.sv]
// self-checking bench of cstd_core with the host dma model
// assumes 125 MHz clock and a flash backend answering commits after 3 cycles
`timescale 1ns/1ps
module test_cstd_core
  import cstd_pkg::*;
;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } cstd_row_t;
  logic        clk = 0, rst = 1, avs_read = 0, avs_write = 0, slow = 0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, dma_request_line, dma_acknowledge_n, io_write_strobe_n;
  logic [15:0] dma_data, buf_rd_data;
  logic        intrq, sleep_mode, security_frozen, sector_commit;
  logic        flash_done = 0, flash_error = 0, sector_erased = 0;
  logic [23:0] erase_count = 24'h0;
  logic [7:0]  buf_rd_idx = 8'h00;
  cstd_chs_t   sector_addr;
  int          fails = 0, samples_checked = 0, commits = 0, err_at = 0;
  cstd_row_t   rows[6] = '{'{REG_SECCNT, 8'h5A, 8'h5A}, '{REG_SECNUM, 8'h3C, 8'h3C}, '{REG_CYL_LO, 8'hC3, 8'hC3},
                           '{REG_DRVHEAD, 8'h13, 8'hB3}, '{6'h30, 8'hFF, 8'h00}, '{REG_DATA, 8'h77, 8'h00}};
  always #4 clk = ~clk;
  cstd_core #(.HEADS(16), .SECT_PER_TRK(63), .HOT_COUNT(1'b1)) dut (.clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .dma_request_line, .dma_acknowledge_n,
    .io_write_strobe_n, .dma_data, .intrq, .sleep_mode, .security_frozen, .sector_commit, .sector_addr,
    .buf_rd_idx, .buf_rd_data, .flash_done, .flash_error, .sector_erased, .erase_count);
  cstd_host_model host (.clk, .rst, .slow, .dma_request_line, .dma_acknowledge_n, .io_write_strobe_n, .dma_data);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    // start on a rising edge even when called after a settle delay
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    chk("bus answer", n < 20, 1'b1);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wait_intr(input int lim);
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("intrq", intrq, 1'b1);
  endtask : wait_intr
  function automatic logic [15:0] rpt(input int i);
    case (i)
      0: return 16'h0200;
      1: return 16'h0403;
      2: return 16'h0800;
      3: return 16'h00A0;
      9: return 16'hFF00;
      12: return 16'hCDAB;
      13: return 16'h00EF;
      default: return 16'h0000;
    endcase
  endfunction : rpt
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // flash backend: answers each sector commit, failing the err_at one
  initial forever begin
    @(posedge clk);
    if (sector_commit === 1'b1) begin
      commits = commits + 1;
      repeat (3) @(posedge clk);
      flash_error <= (commits == err_at);
      flash_done  <= 1'b1;
      @(posedge clk);
      flash_done  <= 1'b0;
      flash_error <= 1'b0;
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    $display("CHECK FAILED watchdog expected done seen hang");
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(0, REG_CMD_STAT, 0);
    chk("status", q[7:0], 8'h40);
    chk("sleep", sleep_mode, 1'b0);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1, rows[i].a, {24'h0, rows[i].d});
      bus(0, rows[i].a, 0);
      chk("task file", q[7:0], rows[i].e);
    end
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      bus(1, REG_CMD_STAT, {24'h0, k ? CMD_STBY_IMM_B : CMD_STBY_IMM_A});
      step(2);
      chk("sleep", {sleep_mode, intrq}, 2'b11);
      bus(1, REG_SECCNT, 32'h5);
      bus(1, REG_CMD_STAT, {24'h0, CMD_WEAR_LEVEL});
      chk("wake", sleep_mode, 1'b0);
      wait_intr(10);
      bus(0, REG_SECCNT, 0);
      chk("wear count", q[7:0], WEAR_NOT_NEED);
    end
    chk("frozen", security_frozen, 1'b0);
    bus(1, REG_CFG, 32'h1);
    bus(1, REG_CMD_STAT, {24'h0, CMD_WEAR_LEVEL});
    step(2);
    chk("frozen", security_frozen, 1'b1);
    bus(1, REG_CFG, 32'h0);
    $display("test standby and wear done");
    bus(1, REG_SECNUM, 32'h4);
    bus(1, REG_CYL_LO, 32'h2);
    bus(1, REG_CYL_HI, 32'h0);
    bus(1, REG_DRVHEAD, 32'h3);
    sector_erased <= 1'b1;
    erase_count   <= 24'hABCDEF;
    bus(1, REG_CMD_STAT, {24'h0, CMD_TRANSLATE});
    bus(0, REG_CMD_STAT, 0);
    chk("drq", q[STAT_DRQ_BIT], 1'b1);
    for (int i = 0; i < 256; i++) begin
      bus(0, REG_DATA, 0);
      chk("report", q[15:0], rpt(i));
    end
    bus(0, REG_CMD_STAT, 0);
    chk("drq", q[STAT_DRQ_BIT], 1'b0);
    $display("test translate done");
    bus(1, REG_CMD_STAT, {24'h0, CMD_WRITE_BUF});
    for (int i = 0; i < 256; i++)
      bus(1, REG_DATA, 32'hC000 + i);
    wait_intr(10);
    buf_rd_idx <= 8'hFF;
    step(2);
    chk("buffer", buf_rd_data, 16'hC0FF);
    bus(1, REG_CFG, 32'h2);
    bus(1, REG_CMD_STAT, {24'h0, CMD_WRITE_DMA});
    step(2);
    chk("request", dma_request_line, 1'b0);
    bus(0, REG_FEAT_ERR, 0);
    chk("abort", q[ERR_ABRT_BIT], 1'b1);
    bus(1, REG_CFG, 32'h0);
    $display("test buffer and abort done");
    slow <= 1'b1;
    bus(1, REG_SECCNT, 32'h2);
    bus(1, REG_SECNUM, 32'h5);
    bus(1, REG_CMD_STAT, {24'h0, CMD_WRITE_DMA});
    wait_intr(20000);
    chk("sectors", commits, 2);
    bus(0, REG_SECNUM, 0);
    chk("last sector", q[7:0], 8'h06);
    chk("buffer", buf_rd_data, 16'h01FF);
    slow <= 1'b0;
    commits = 0;
    err_at  = 3;
    bus(1, REG_SECCNT, 32'h0);
    bus(1, REG_SECNUM, 32'h1);
    bus(1, REG_CMD_STAT, {24'h0, CMD_WRITE_DMA});
    wait_intr(20000);
    chk("sectors", commits, 3);
    bus(0, REG_SECNUM, 0);
    chk("fail sector", q[7:0], 8'h03);
    bus(0, REG_CMD_STAT, 0);
    chk("error", q[STAT_ERR_BIT], 1'b1);
    $display("test dma done");
    summarize();
  end
endmodule : test_cstd_core
